// ### hdl/dram_cycle_timing.v
`timescale 1ns/10ps
`include "dram_timing_consts.vh"
// Overview of operation
// - With penalty bit clear, a read right after a write gets one wait.
// - EMS and interleave-miss cycles may take one extra wait like that penalty.
// - Write CAS delay code selects 1.0 to 2.5 double-rate clocks.
// - Read CAS delay code selects 1.0 to 2.5 double-rate clocks.
// - RAS hold code keeps RAS 1.0 to 2.5 clocks after CAS.
// - RAS time shortens half a clock when the active delay code is 1X.
// - Pulse extension adds half a clock per step to the two-clock CAS.
// - CAS width shrinks half clock for write X1 or read 1X codes.
// - Wait-state code adds zero to three waits to every non-page DRAM cycle.
// - Timing register bits 15 and 7 are ignored.
// - Row address leads RAS by two; RAS hold follows the mode formula.
// - Non-page cycle lasts twice two plus wait code; precharge is the rest.
// - Plain 16-bit processor page waits are 0,1,2 writes and 0,1,2,3 reads.
// - With cache, reads cost 0,1,3,4; writes stay 0,1,2.
// - Non-pipelined cycles cost more; read page miss four, first access three.
// - After refresh, DMA or master, a page cycle is a shorter first access.
// - First-access shortening needs uniform DRAMs and never an EMS cycle.
// - Mode selects full hold with one wait minimum or compressed zero-wait.
module dram_cycle_timing #(
	parameter ROW_W  = 11,
	parameter BANK_W = 2
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [3:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [3:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              cycle_start,
	input  wire              cycle_write,
	input  wire              page_mode,
	input  wire [BANK_W-1:0] cycle_bank,
	input  wire [ROW_W-1:0]  cycle_row,
	input  wire              cycle_ems,
	input  wire              interleave_miss,
	input  wire              cache_hit,
	input  wire              after_other_master,
	output reg               ras_active,
	output reg               cas_active,
	output reg               row_addr_sel,
	output reg               cycle_ready,
	output reg  [2:0]        waits_taken
);
	// ****************************************************************
	// Register file.
	// ****************************************************************
	reg  [15:0]       timing;
	reg  [3:0]        page_cfg;
	reg  [3:0]        aw_addr;
	reg               aw_held;
	reg  [31:0]       w_data;
	reg  [3:0]        w_strb;
	reg               w_held;
	reg               last_was_write;
	reg  [ROW_W-1:0]  open_row [0:(1<<BANK_W)-1];
	reg  [(1<<BANK_W)-1:0] row_valid;
	reg  [1:0]        state;
	reg  [7:0]        tick;
	reg  [7:0]        cycle_len;
	reg  [7:0]        ras_on;
	reg  [7:0]        ras_off;
	reg  [7:0]        cas_on;
	reg  [7:0]        cas_off;
	reg  [15:0]       next_timing;
	integer           i;

	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_DONE = 2'h2;

	// Field views of the timing register.
	wire [1:0] nonpage_timing_mode          = timing[`MODE_HI:`MODE_LO];
	wire       read_after_write_penalty_off = timing[`RAW_OFF_BIT];
	wire [1:0] write_cas_delay              = timing[`WCAS_HI:`WCAS_LO];
	wire [1:0] read_cas_delay               = timing[`RCAS_HI:`RCAS_LO];
	wire       hold_high_bit                = timing[`HOLD_HI_BIT];
	wire       hold_low_bit                 = timing[`HOLD_LO_BIT];
	wire [2:0] cas_pulse_extension          = timing[`PWE_HI:`PWE_LO];
	wire [1:0] added_wait_states            = timing[`WS_HI:`WS_LO];

	// Merge one byte lane set into a stored word.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge16 = old;
			if (strb[0]) merge16[7:0] = data[7:0];
			if (strb[1]) merge16[15:8] = data[15:8];
		end
	endfunction

	always @* begin
		next_timing = merge16(timing, w_data, w_strb) & `TIMING_USED_MASK;
	end

	// Write channel: address and data accepted in either order.
	// New timing is live at once, so the code writing it must not run from DRAM.
	always @(posedge aclk) begin
		if (!aresetn) begin
			timing        <= `RESET_NONPAGE_TIMING;
			page_cfg      <= `RESET_PAGE_CONFIG;
			aw_addr       <= 4'h0;
			aw_held       <= 1'b0;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			w_held        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				case (aw_addr)
					`ADDR_NONPAGE_TIMING: timing <= next_timing;
					`ADDR_PAGE_CONFIG: begin
						if (w_strb[0]) page_cfg <= w_data[3:0];
					end
					`ADDR_CYCLE_STATUS: s_axi_bresp <= `RESP_OKAY;
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel; one outstanding read.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RESP_OKAY;
				case (s_axi_araddr)
					`ADDR_NONPAGE_TIMING: s_axi_rdata <= {16'h0, timing};
					`ADDR_PAGE_CONFIG:    s_axi_rdata <= {28'h0, page_cfg};
					`ADDR_CYCLE_STATUS:   s_axi_rdata <= {24'h0, row_valid[0],
						last_was_write, waits_taken, state, cycle_ready};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Page-mode classification.
	// ****************************************************************
	wire row_match = row_valid[cycle_bank] && (open_row[cycle_bank] == cycle_row);
	wire first_ok  = after_other_master && page_cfg[`CFG_SAME_CFG] && !cycle_ems;
	wire [1:0] page_kind = row_match ? 2'h0 : (first_ok ? 2'h1 : 2'h2);
	wire raw_due = !cycle_write && last_was_write && !read_after_write_penalty_off;
	wire extra_wait = raw_due || cycle_ems || interleave_miss;
	wire [2:0] page_waits;

	page_wait_lookup u_lookup (
		.is_write  (cycle_write),
		.raw_hit   (raw_due),
		.page_kind (page_kind),
		.pipe_cpu  (page_cfg[`CFG_PIPE_CPU]),
		.cache_on  (page_cfg[`CFG_CACHE]),
		.cache_hit (cache_hit),
		.pipelined (page_cfg[`CFG_PIPELINE]),
		.waits     (page_waits)
	);

	// ****************************************************************
	// Non-page strobe schedule in half double-rate clock units.
	// ****************************************************************
	// One aclk tick stands for half a double-rate period; edges land exactly.
	wire [1:0] dly      = cycle_write ? write_cas_delay : read_cas_delay;
	wire       dly_low  = dly[0];
	wire       dly_hi   = dly[1];
	wire       compress = (nonpage_timing_mode == 2'h1);
	wire [2:0] np_waits = {1'b0, added_wait_states} + {2'b0, extra_wait};
	// Full-hold mode needs at least one wait state.
	wire [2:0] np_eff   = (!compress && np_waits == 3'h0) ? 3'h1 : np_waits;
	wire [7:0] np_len   = (`BASE_CYCLE_CLKS + {5'h0, np_eff}) << 2;
	wire [7:0] c_on     = `ROW_TO_RAS_HALVES + (compress ? 8'h1 : 8'h2)
		+ {6'h0, dly};
	wire [2:0] ext_code = cas_pulse_extension;
	wire       shrink   = cycle_write ? write_cas_delay[0] : read_cas_delay[1];
	wire [7:0] c_width  = 8'h4 + {5'h0, ext_code} - {7'h0, shrink};
	wire [7:0] r_hold   = (compress ? 8'h1 : 8'h2) + {7'h0, hold_low_bit}
		+ {6'h0, hold_high_bit, 1'b0} - {7'h0, dly_hi};

	// Cycle engine; ready is held for one tick per cycle end.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state          <= ST_IDLE;
			tick           <= 8'h0;
			cycle_len      <= 8'h0;
			ras_on         <= 8'h0;
			ras_off        <= 8'h0;
			cas_on         <= 8'h0;
			cas_off        <= 8'h0;
			ras_active     <= 1'b0;
			cas_active     <= 1'b0;
			row_addr_sel   <= 1'b0;
			cycle_ready    <= 1'b0;
			waits_taken    <= 3'h0;
			last_was_write <= 1'b0;
			row_valid      <= {(1<<BANK_W){1'b0}};
			for (i = 0; i < (1<<BANK_W); i = i + 1) begin
				open_row[i] <= {ROW_W{1'b0}};
			end
		end else begin
			cycle_ready <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cycle_start) begin
						state          <= ST_RUN;
						tick           <= 8'h0;
						row_addr_sel   <= 1'b1;
						last_was_write <= cycle_write;
						if (page_mode) begin
							waits_taken <= page_waits;
							cycle_len   <= {4'h0, page_waits, 1'b0} + 8'h4;
							ras_on      <= (page_kind == 2'h0) ? 8'h0 : `ROW_TO_RAS_HALVES;
							cas_on      <= (page_kind == 2'h0) ? 8'h1 : 8'h6;
							cas_off     <= {4'h0, page_waits, 1'b0} + 8'h4;
							ras_off     <= 8'hFF;
							open_row[cycle_bank]  <= cycle_row;
							row_valid[cycle_bank] <= 1'b1;
						end else begin
							waits_taken <= np_eff;
							cycle_len   <= np_len;
							ras_on      <= `ROW_TO_RAS_HALVES;
							cas_on      <= c_on;
							cas_off     <= c_on + c_width;
							ras_off     <= c_on + r_hold;
							row_valid   <= {(1<<BANK_W){1'b0}};
						end
					end
				end
				ST_RUN: begin
					tick <= tick + 8'h1;
					if (tick == ras_on) ras_active <= 1'b1;
					if (tick == cas_on) begin
						cas_active   <= 1'b1;
						row_addr_sel <= 1'b0;
					end
					if (tick == cas_off) cas_active <= 1'b0;
					if (tick == ras_off) ras_active <= 1'b0;
					if (tick + 8'h1 >= cycle_len) begin
						state       <= ST_DONE;
						cas_active  <= 1'b0;
						cycle_ready <= 1'b1;
						if (!page_mode) ras_active <= 1'b0;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // dram_cycle_timing

// ### hdl/dram_timing_consts.vh
`ifndef DRAM_TIMING_CONSTS_VH
`define DRAM_TIMING_CONSTS_VH
// ****************************************************************
// Register map.
// ****************************************************************
`define ADDR_NONPAGE_TIMING 4'h0
`define ADDR_PAGE_CONFIG    4'h4
`define ADDR_CYCLE_STATUS   4'h8
`define RESET_NONPAGE_TIMING 16'h0000
`define RESET_PAGE_CONFIG    4'h0
// ****************************************************************
// Timing register fields.
// ****************************************************************
`define MODE_HI      14
`define MODE_LO      13
`define RAW_OFF_BIT  12
`define WCAS_HI      11
`define WCAS_LO      10
`define RCAS_HI      9
`define RCAS_LO      8
`define HOLD_HI_BIT  6
`define HOLD_LO_BIT  5
`define PWE_HI       4
`define PWE_LO       2
`define WS_HI        1
`define WS_LO        0
// Timing register bits that are stored; bits 15 and 7 are ignored.
`define TIMING_USED_MASK 16'h7F7F
// ****************************************************************
// Page configuration fields.
// ****************************************************************
`define CFG_PIPE_CPU 0
`define CFG_CACHE    1
`define CFG_PIPELINE 2
`define CFG_SAME_CFG 3
// ****************************************************************
// Fixed timing figures: row lead in half double-rate clock units, base cycle in steps of four halves.
// ****************************************************************
`define ROW_TO_RAS_HALVES 8'h04
`define BASE_CYCLE_CLKS   8'h02
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hdl/page_wait_lookup.v
`timescale 1ns/10ps
`include "dram_timing_consts.vh"
module page_wait_lookup (
	input  wire       is_write,
	input  wire       raw_hit,
	input  wire [1:0] page_kind,
	input  wire       pipe_cpu,
	input  wire       cache_on,
	input  wire       cache_hit,
	input  wire       pipelined,
	output reg  [2:0] waits
);
	// Page kinds: 0 hit, 1 first access, 2 miss.
	// ****************************************************************
	// Wait-state table.
	// ****************************************************************
	// Combinational lookup keeps the main cycle engine free of tables.
	always @* begin
		waits = 3'h0;
		if (is_write) begin
			case (page_kind)
				2'h0: waits = (pipe_cpu && !pipelined && !cache_on) ? 3'h1 : 3'h0;
				2'h1: waits = 3'h1;
				default: waits = (pipe_cpu && !pipelined && !cache_on) ? 3'h3 : 3'h2;
			endcase
		end else if (cache_on) begin
			if (cache_hit) begin
				waits = 3'h0;
			end else begin
				case (page_kind)
					2'h0: waits = 3'h1;
					2'h1: waits = 3'h3;
					default: waits = 3'h4;
				endcase
			end
		end else if (pipe_cpu) begin
			case (page_kind)
				2'h0: waits = pipelined ? (raw_hit ? 3'h1 : 3'h0) : 3'h1;
				2'h1: waits = 3'h3;
				default: waits = pipelined ? 3'h3 : 3'h4;
			endcase
		end else begin
			case (page_kind)
				2'h0: waits = raw_hit ? 3'h1 : 3'h0;
				2'h1: waits = 3'h2;
				default: waits = 3'h3;
			endcase
		end
	end
endmodule // page_wait_lookup

// ### sim/dram_timing_checker_assertions.sv
`timescale 1ns/10ps
`include "dram_timing_consts.vh"
// ****************
// Port checker for the DRAM timing block.
// ****************
module dram_timing_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        ras_active,
	input wire logic        cas_active,
	input wire logic        row_addr_sel,
	input wire logic        cycle_ready,
	input wire logic [2:0]  waits_taken
);
	logic [3:0] rd_addr;
	// The read answer does not carry its address, so keep it from the request.
	always @(posedge aclk) begin
		if (!aresetn)
			rd_addr <= 4'h0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	ready_one_cycle_a: assert property (cycle_ready |=> !cycle_ready)
		else $error("cycle end pulse lasted more than one cycle");
	cas_inside_ras_a: assert property ($rose(cas_active) |-> ras_active)
		else $error("column strobe rose without row strobe");
	row_leads_ras_a: assert property ($rose(ras_active) |-> $past(row_addr_sel, 4))
		else $error("row address did not lead the row strobe");
	reset_clears_a: assert property ($rose(aresetn) |-> !ras_active && !cas_active)
		else $error("strobes active right after reset");
	bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before it was taken");
	rdata_holds_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed before it was taken");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	refused_zero_a: assert property (
		s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	unused_bits_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_OKAY &&
		rd_addr == `ADDR_NONPAGE_TIMING |-> (s_axi_rdata & 32'hFFFF8080) == 32'h0)
		else $error("unused timing bits read back set");
	cover property (cycle_ready && waits_taken == 3'h4);
	cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
	cover property ($rose(cas_active));
endmodule // dram_timing_checker
bind dram_cycle_timing dram_timing_checker chk_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .ras_active(ras_active), .cas_active(cas_active),
	.row_addr_sel(row_addr_sel), .cycle_ready(cycle_ready), .waits_taken(waits_taken));

// ### sim/dram_module_model.sv
`timescale 1ns/10ps
// ****************
// Memory module side: times the strobes it receives, in clock ticks.
// ****************
module dram_module_model (
	input wire logic aclk,
	input wire logic ras_active,
	input wire logic cas_active,
	output int       ras_w = 0,
	output int       cas_w = 0,
	output int       ras_to_cas = 0
);
	int   cnt = 0;
	int   t_ras = 0;
	int   t_cas = 0;
	logic ras_q = 1'b0;
	logic cas_q = 1'b0;
	// Edge times are kept so widths are reported once each pulse ends; ras_to_cas is reported at the column strobe rise.
	always @(posedge aclk) begin
		cnt <= cnt + 1;
		ras_q <= ras_active;
		cas_q <= cas_active;
		if (ras_active && !ras_q)
			t_ras <= cnt;
		if (!ras_active && ras_q)
			ras_w <= cnt - t_ras;
		if (cas_active && !cas_q)
			t_cas <= cnt;
		if (cas_active && !cas_q)
			ras_to_cas <= cnt - t_ras;
		if (!cas_active && cas_q)
			cas_w <= cnt - t_cas;
	end
endmodule // dram_module_model

// ### sim/testbench.sv
`timescale 1ns/10ps
`include "dram_timing_consts.vh"
// ****************
// Self-checking bench for the DRAM timing block.
// ****************
module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        cycle_start = 1'b0, cycle_write = 1'b0, page_mode = 1'b0, cycle_ems = 1'b0;
	logic        interleave_miss = 1'b0, cache_hit = 1'b0, after_other_master = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic [10:0] cycle_row = 11'h0;
	logic [1:0]  r;
	logic [2:0]  w;
	logic [15:0] v;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [2:0]  waits_taken;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         ras_active, cas_active, row_addr_sel, cycle_ready;
	int          error_cnt = 0, compares = 0, len, db, eb, ras_w, cas_w, ras_to_cas;
	// Page table: wait[15:13] write[12] first[11] cache hit[10] config[7:4] row[3:0].
	// The bank is the low two bits of the row, so open rows are kept per bank.
	logic [15:0] tbl [19] = '{16'h3881, 16'h1081, 16'h5082, 16'h2082, 16'h0082, 16'h6083,
		16'h4884, 16'h04A4, 16'h20A4, 16'h80A5, 16'h68A6, 16'h8097, 16'h6898, 16'h8819,
		16'h60DA, 16'h00DA, 16'h10DA, 16'h20DA, 16'h00D7};
	always #25 aclk = ~aclk;
	dram_cycle_timing dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
		.s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cycle_start(cycle_start), .cycle_write(cycle_write),
		.page_mode(page_mode), .cycle_bank(cycle_row[1:0]), .cycle_row(cycle_row),
		.cycle_ems(cycle_ems),
		.interleave_miss(interleave_miss), .cache_hit(cache_hit), .ras_active(ras_active),
		.after_other_master(after_other_master), .cas_active(cas_active),
		.row_addr_sel(row_addr_sel), .cycle_ready(cycle_ready), .waits_taken(waits_taken));
	dram_module_model dram (.aclk(aclk), .ras_active(ras_active), .cas_active(cas_active),
		.ras_w(ras_w), .cas_w(cas_w), .ras_to_cas(ras_to_cas));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task hang(input int n);
		if (n > 200) begin
			error_cnt++;
			summarize();
		end
	endtask
	// Address and data are offered together and each is released once taken.
	task axi_wr(input logic [3:0] a, input logic [31:0] dt);
		int n;
		@(posedge aclk);
		n = 0;
		{s_axi_awaddr, s_axi_wdata} <= {a, dt};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			n++;
			hang(n);
			// Ready stays low after its handshake, so each valid drops once taken.
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [3:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do begin
			@(posedge aclk);
			n++;
			hang(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	// Flags are {first access, cache hit, interleave miss, remapped}.
	task run(input logic wr, input logic pg, input logic [3:0] row, input logic [3:0] fl);
		int n;
		@(posedge aclk);
		n = 0;
		{cycle_start, cycle_write, page_mode, cycle_row} <= {1'b1, wr, pg, 7'h0, row};
		{after_other_master, cache_hit, interleave_miss, cycle_ems} <= fl;
		@(posedge aclk);
		cycle_start <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
			hang(n);
		end while (!cycle_ready);
		{len, w} = {n, waits_taken};
		repeat (2) @(posedge aclk);
	endtask
	// Mode 01 with the read penalty off; both delay fields get the same code.
	function logic [15:0] tv(input logic [1:0] c, h, input logic [2:0] p, input logic [1:0] k);
		return {4'b0011, c, c, 1'b0, h, p, k};
	endfunction
	initial begin
		void'($urandom(32'hA823));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(`ADDR_NONPAGE_TIMING);
		chk(d, 32'h0);
		axi_rd(4'hC);
		chk(d, 32'h0);
		chk(r, `RESP_SLVERR);
		// Timing is rewritten only between DRAM cycles, since it takes effect at once.
		for (int i = 0; i < 9; i++) begin
			v = (i == 0) ? 16'hFFFF : 16'($urandom);
			axi_wr(`ADDR_NONPAGE_TIMING, {16'h0, v});
			axi_rd(`ADDR_NONPAGE_TIMING);
			chk(d, {16'h0, v & 16'h7F7F});
		end
		for (int k = 0; k < 4; k++) begin
			axi_wr(`ADDR_NONPAGE_TIMING, tv(2'h0, 2'h0, 3'h0, 2'(k)));
			run(1'b1, 1'b0, 4'h0, 4'h0);
			// Ticks are half double-rate periods; one more edge is spent seeing the registered ready.
			chk(w, 3'(k));
			chk(len, 4 * (2 + k) + 1);
		end
		axi_wr(`ADDR_NONPAGE_TIMING, 32'h1000);
		run(1'b1, 1'b0, 4'h0, 4'h0);
		chk(w, 1);
		// Each code step should move the measured strobe edge by one tick.
		for (int s = 0; s < 4; s++) begin
			axi_wr(`ADDR_NONPAGE_TIMING, tv(2'h0, 2'(s), 3'h0, 2'h3));
			run(1'b1, 1'b0, 4'h0, 4'h0);
			chk(ras_w, 2 + s);
			axi_wr(`ADDR_NONPAGE_TIMING, tv(2'h0, 2'h0, 3'(s), 2'h3));
			run(1'b1, 1'b0, 4'h0, 4'h0);
			chk(cas_w, 4 + s);
			// A nonzero hold keeps the row strobe up past the column strobe rise.
			axi_wr(`ADDR_NONPAGE_TIMING, tv(2'(s), 2'h2, 3'h0, 2'h3));
			run(1'b1, 1'b0, 4'h0, 4'h0);
			if (s == 0) db = ras_to_cas;
			chk(ras_to_cas - db, s);
			chk(cas_w, 4 - s[0]);
			run(1'b0, 1'b0, 4'h0, 4'h0);
			if (s == 0) eb = ras_to_cas;
			chk(ras_to_cas - eb, s);
			chk(cas_w, 4 - s[1]);
		end
		axi_wr(`ADDR_NONPAGE_TIMING, 32'h2000);
		run(1'b1, 1'b0, 4'h0, 4'h0);
		run(1'b0, 1'b0, 4'h0, 4'h0);
		chk(w, 1);
		run(1'b0, 1'b0, 4'h0, 4'h1);
		chk(w, 1);
		run(1'b0, 1'b0, 4'h0, 4'h2);
		chk(w, 1);
		foreach (tbl[i]) begin
			axi_wr(`ADDR_PAGE_CONFIG, {28'h0, tbl[i][7:4]});
			run(tbl[i][12], 1'b1, tbl[i][3:0], {tbl[i][11:10], 2'h0});
			chk(w, tbl[i][15:13]);
		end
		summarize();
	end
endmodule // testbench
